// [rtl/hipc_params.svh]
// Constants for the halt and idle power sequencer.
`ifndef HIPC_PARAMS_SVH
`define HIPC_PARAMS_SVH

// Oscillator period and instruction cycle period, in nanoseconds.
`define HIPC_CLK_PERIOD_NS 100
`define HIPC_TC_PERIOD_NS 1000
// Oscillator cycles per instruction cycle; ten at these rates.
`define HIPC_TC_DIV (`HIPC_TC_PERIOD_NS / `HIPC_CLK_PERIOD_NS)
`define HIPC_DIV_W 4
`define HIPC_DIV_LAST 4'h9

// Idle timer layout and start-up load.
`define HIPC_TMR_W 16
`define HIPC_START_LOAD 16'h0100
`define HIPC_TMR_RESET 16'h0000
`define HIPC_TMR_ZERO 16'h0000
`define HIPC_TMR_ONE 16'h0001
`define HIPC_TOGGLE_BIT 12

// Port M wake enable bit that arms the CAN wake-up comparator.
`define HIPC_CAN_WAKE_BIT 7
`define HIPC_WAKE_W 8

`endif

// [rtl/hipc_pkg.sv]
// Types shared by the halt and idle power sequencer.
package hipc_pkg;

   typedef enum logic [1:0] {
      HIPC_RUN = 2'b00,
      HIPC_HALT = 2'b01,
      HIPC_IDLE = 2'b10,
      HIPC_START = 2'b11
   } hipc_state_t;

   typedef struct packed {
      hipc_state_t mode;
      logic osc_enable;
      logic sys_clk_enable;
      logic timer_run;
   } hipc_status_t;

   typedef struct packed {
      logic main_comp_on;
      logic wake_comp_on;
      logic vref_on;
   } hipc_can_t;

endpackage

// [rtl/hipc_sync.sv]
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module hipc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [rtl/hipc_tc_div.sv]
// Divider that makes the instruction cycle tick from the oscillator clock.
`timescale 1ns/1ps
`include "hipc_params.svh"
module hipc_tc_div (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   logic [`HIPC_DIV_W-1:0] cnt_r;

   // The count restarts whenever the oscillator is stopped.
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_r <= '0;
      end else if (cnt_r == `HIPC_DIV_LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + `HIPC_DIV_W'(1);
      end
   end

   assign tick = run && (cnt_r == `HIPC_DIV_LAST);
endmodule

// [rtl/hipc_top.sv]
// Halt and idle power-save sequencer with start-up delay and CAN power-down.
//
// Overview of operation
// - Writing one to the halt request bit enters HALT when the halt option allows.
// - HALT stops the oscillator, the system clocks and every timer.
// - Writing one to the idle request bit enters IDLE; only oscillator and idle timer run.
// - HALT and IDLE keep all state except the idle timer unchanged.
// - Clearing port M wake enable bit 7 stops CAN traffic waking the device.
// - With both CAN comparators off, the reference is off and its pin floats.
// - HALT ends on a port L or M wake-up or a low reset pin.
// - A HALT wake-up runs only the oscillator and counts 256 down on tc.
// - The instruction clock is the oscillator divided by ten.
// - System clocks stay gated until the start-up count expires.
// - With the halt option disabled, halt request writes are ignored.
// - IDLE ends on reset or on a port L or CAN wake-up.
// - IDLE also ends when idle timer bit twelve toggles.
// - Each toggle of idle timer bit twelve sets the pending flag.
// - The idle timer interrupt is raised only while its enable is set.
// - Timer exit from IDLE with interrupt enabled runs the service routine first.
// - Timer exit from IDLE with interrupt disabled resumes at the next instruction.
// - Each selected timer bit event clears the idle request bit.
// - HALT is refused while any wake-up bit is enabled and pending.
`timescale 1ns/1ps
`include "hipc_params.svh"
module hipc_top
   import hipc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic halt_option_en,
   input wire logic halt_req_wr,
   input wire logic halt_req_wdata,
   input wire logic idle_req_wr,
   input wire logic idle_req_wdata,
   input wire logic can_rx_comp_enable_0,
   input wire logic can_rx_comp_enable_1,
   input wire logic [`HIPC_WAKE_W-1:0] portm_wake_enable_reg,
   input wire logic [`HIPC_WAKE_W-1:0] portm_wake_pending,
   input wire logic [`HIPC_WAKE_W-1:0] portl_wake_enable,
   input wire logic [`HIPC_WAKE_W-1:0] portl_wake_pending,
   input wire logic reset_pin_n,
   input wire logic idle_timer_int_enable,
   input wire logic idle_timer_pending_clr,
   output logic halt_request_bit,
   output logic idle_request_bit,
   output hipc_status_t status,
   output hipc_can_t can_power,
   output logic can_vref_oe_n,
   output logic [`HIPC_TMR_W-1:0] idle_timer,
   output logic idle_timer_pending,
   output logic idle_timer_irq,
   output logic resume_isr,
   output logic resume_next
);
   hipc_state_t state_r;
   hipc_state_t state_nxt;
   logic halt_request_r;
   logic idle_request_r;
   logic [`HIPC_TMR_W-1:0] timer_r;
   logic [`HIPC_TMR_W-1:0] timer_nxt;
   logic pending_r;
   logic irq_r;
   logic resume_isr_r;
   logic resume_next_r;
   logic osc_run;
   logic tc_tick;
   logic timer_step;
   logic toggle_evt;
   logic reset_pin_n_s;
   logic pin_reset;
   logic wake_any;
   logic halt_take;
   logic idle_take;
   logic timer_exit;
   logic start_done;

   // The reset pin comes from outside the clock domain.
   hipc_sync #(
      .W(1),
      .INIT(1'b1)
   ) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .d(reset_pin_n),
      .q(reset_pin_n_s)
   );

   assign pin_reset = !reset_pin_n_s;

   // The oscillator is stopped only while halted.
   assign osc_run = (state_r != HIPC_HALT);

   hipc_tc_div u_tc_div (
      .clk(clk),
      .rst(rst),
      .run(osc_run),
      .tick(tc_tick)
   );

   // Pending flags arrive from the wake-up edge logic on this clock.
   // Port M bit 7 is the CAN wake-up input; its enable arms the comparator.
   assign wake_any = |(portl_wake_enable & portl_wake_pending)
                     | |(portm_wake_enable_reg & portm_wake_pending);

   // A halt request with a wake-up already pending would never sleep, so it is refused.
   assign halt_take = (state_r == HIPC_RUN) && halt_req_wr && halt_req_wdata
                      && halt_option_en && !wake_any;
   assign idle_take = (state_r == HIPC_RUN) && idle_req_wr && idle_req_wdata
                      && !halt_take;

   assign timer_step = tc_tick && (state_r != HIPC_HALT);
   assign timer_nxt = timer_r - `HIPC_TMR_ONE;
   assign toggle_evt = timer_step && (state_r != HIPC_START)
                       && (timer_nxt[`HIPC_TOGGLE_BIT] != timer_r[`HIPC_TOGGLE_BIT]);
   assign timer_exit = (state_r == HIPC_IDLE) && toggle_evt;
   assign start_done = (state_r == HIPC_START) && (timer_r == `HIPC_TMR_ZERO);

   // Sequencer.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HIPC_RUN: begin
            if (pin_reset) begin
               state_nxt = HIPC_RUN;
            end else if (halt_take) begin
               state_nxt = HIPC_HALT;
            end else if (idle_take) begin
               state_nxt = HIPC_IDLE;
            end
         end
         HIPC_HALT: begin
            if (wake_any || pin_reset) begin
               state_nxt = HIPC_START;
            end
         end
         HIPC_IDLE: begin
            // The oscillator never stopped, so no start-up delay is needed.
            if (pin_reset || wake_any || toggle_evt) begin
               state_nxt = HIPC_RUN;
            end
         end
         HIPC_START: begin
            if (start_done) begin
               state_nxt = HIPC_RUN;
            end
         end
         default: begin
            state_nxt = HIPC_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= HIPC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Request bits read back to software.
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_request_r <= 1'b0;
      end else if (state_nxt == HIPC_RUN) begin
         halt_request_r <= 1'b0;
      end else if (halt_take) begin
         halt_request_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         idle_request_r <= 1'b0;
      end else if (toggle_evt || state_nxt == HIPC_RUN) begin
         idle_request_r <= 1'b0;
      end else if (idle_take) begin
         idle_request_r <= 1'b1;
      end
   end

   // Idle timer: frozen in HALT, loaded on a HALT wake-up, else free running down.
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_r <= `HIPC_TMR_RESET;
      end else if (state_r == HIPC_HALT) begin
         if (state_nxt == HIPC_START) begin
            timer_r <= `HIPC_START_LOAD;
         end
      end else if (start_done) begin
         timer_r <= timer_r;
      end else if (timer_step) begin
         timer_r <= timer_nxt;
      end
   end

   // A toggle in the same cycle as a clear keeps the flag set.
   always_ff @(posedge clk) begin
      if (rst) begin
         pending_r <= 1'b0;
      end else if (toggle_evt) begin
         pending_r <= 1'b1;
      end else if (idle_timer_pending_clr) begin
         pending_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= pending_r && idle_timer_int_enable;
      end
   end

   // Resume direction after a timer exit from IDLE.
   always_ff @(posedge clk) begin
      if (rst) begin
         resume_isr_r <= 1'b0;
         resume_next_r <= 1'b0;
      end else begin
         resume_isr_r <= timer_exit && idle_timer_int_enable;
         resume_next_r <= timer_exit && !idle_timer_int_enable;
      end
   end

   assign halt_request_bit = halt_request_r;
   assign idle_request_bit = idle_request_r;
   assign idle_timer = timer_r;
   assign idle_timer_pending = pending_r;
   assign idle_timer_irq = irq_r;
   assign resume_isr = resume_isr_r;
   assign resume_next = resume_next_r;

   // Gating the system clock freezes RAM, registers and ports in place.
   // Software must still pad with two no-operations, since the gate lands mid-instruction.
   assign status.mode = state_r;
   assign status.osc_enable = osc_run;
   assign status.sys_clk_enable = (state_r == HIPC_RUN);
   assign status.timer_run = osc_run;

   // Software drops both receive enables before sleeping, so main_comp_on
   // falls and the reference may power down.
   assign can_power.main_comp_on = can_rx_comp_enable_0 || can_rx_comp_enable_1;
   assign can_power.wake_comp_on = portm_wake_enable_reg[`HIPC_CAN_WAKE_BIT];
   assign can_power.vref_on = can_power.main_comp_on || can_power.wake_comp_on;
   assign can_vref_oe_n = !can_power.vref_on;

   property p_halt_option;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_RUN && halt_req_wr && halt_req_wdata && !halt_option_en)
         |=> (state_r != HIPC_HALT) && !halt_request_bit;
   endproperty
   a_halt_option: assert property (p_halt_option) else $error("halt entered with option off");

   property p_halt_enter;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_RUN && halt_req_wr && halt_req_wdata && halt_option_en && !wake_any && !pin_reset)
         |=> (state_r == HIPC_HALT) && halt_request_bit;
   endproperty
   a_halt_enter: assert property (p_halt_enter) else $error("halt request not taken");

   property p_halt_refuse;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_RUN && halt_req_wr && wake_any) |=> (state_r != HIPC_HALT);
   endproperty
   a_halt_refuse: assert property (p_halt_refuse) else $error("halt taken with wake pending");

   property p_halt_frozen;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_HALT) |-> !status.osc_enable && !status.sys_clk_enable
         && (($past(state_r) != HIPC_HALT) || (timer_r == $past(timer_r)));
   endproperty
   a_halt_frozen: assert property (p_halt_frozen) else $error("activity during halt");

   property p_idle_run;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_IDLE) |-> status.osc_enable && !status.sys_clk_enable;
   endproperty
   a_idle_run: assert property (p_idle_run) else $error("idle clocks wrong");

   property p_halt_wake;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_HALT && wake_any)
         |=> (state_r == HIPC_START) && (timer_r == `HIPC_START_LOAD) && !status.sys_clk_enable;
   endproperty
   a_halt_wake: assert property (p_halt_wake) else $error("halt wake without start load");

   property p_start_gate;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_START && timer_r != `HIPC_TMR_ZERO) |=> !status.sys_clk_enable;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("clocks released early");

   property p_start_done;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_START && timer_r == `HIPC_TMR_ZERO)
         |=> status.sys_clk_enable && !halt_request_bit;
   endproperty
   a_start_done: assert property (p_start_done) else $error("start-up expiry ignored");

   property p_tc_spacing;
      @(posedge clk) disable iff (rst)
      (tc_tick && state_r != HIPC_HALT) |=> !tc_tick [*8] ##1 !tc_tick;
   endproperty
   a_tc_spacing: assert property (p_tc_spacing) else $error("instruction tick too soon");

   property p_idle_timer_exit;
      @(posedge clk) disable iff (rst)
      (state_r == HIPC_IDLE && toggle_evt)
         |=> (state_r == HIPC_RUN) && !idle_request_bit && idle_timer_pending;
   endproperty
   a_idle_timer_exit: assert property (p_idle_timer_exit) else $error("idle not left on toggle");

   property p_irq_gate;
      @(posedge clk) disable iff (rst)
      idle_timer_irq |-> $past(pending_r) && $past(idle_timer_int_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

   property p_resume_path;
      @(posedge clk) disable iff (rst)
      timer_exit |=> (resume_isr == $past(idle_timer_int_enable)) && (resume_next != resume_isr);
   endproperty
   a_resume_path: assert property (p_resume_path) else $error("wrong resume path");

   property p_vref;
      @(posedge clk) disable iff (rst)
      (!can_rx_comp_enable_0 && !can_rx_comp_enable_1 && !portm_wake_enable_reg[`HIPC_CAN_WAKE_BIT])
         |-> can_vref_oe_n && !can_power.vref_on;
   endproperty
   a_vref: assert property (p_vref) else $error("reference on with comparators off");

endmodule

// [sim/hipc_wake_model.sv]
// Behavioural wake-up pins and reset pin facing the sequencer.
`timescale 1ns/1ps
module hipc_wake_model (
   input wire logic clk,
   input wire logic [15:0] ev,
   input wire logic clr,
   input wire logic press,
   output logic [7:0] portl_pend,
   output logic [7:0] portm_pend,
   output logic reset_pin_n
);
   // Pending flags stay set until software clears them, like the real latches.
   always_ff @(posedge clk) begin
      if (clr) begin
         {portm_pend, portl_pend} <= '0;
      end else begin
         {portm_pend, portl_pend} <= {portm_pend, portl_pend} | ev;
      end
   end
   initial reset_pin_n = 1'b1;
   // The pin is asynchronous, so it moves well away from any clock edge.
   always @(press) begin
      #37 reset_pin_n = ~press;
   end
endmodule

// [sim/tb_halt_idle_power_control.sv]
// Self-checking bench for the halt and idle power sequencer.
`timescale 1ns/1ps
`include "hipc_params.svh"
module tb_halt_idle_power_control
   import hipc_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic opt = 1'b1;
   logic hwr = 1'b0;
   logic iwr = 1'b0;
   logic wd = 1'b1;
   logic en0 = 1'b1;
   logic en1 = 1'b1;
   logic ien = 1'b1;
   logic pclr = 1'b0;
   logic clr = 1'b1;
   logic press = 1'b0;
   logic [7:0] mwen = 8'h00;
   logic [7:0] lwen = 8'h00;
   logic [15:0] ev = 16'h0000;
   logic [7:0] lp, mp;
   logic rpin_n, hbit, ibit, oe_n, pend, irq, risr, rnext;
   hipc_status_t st;
   hipc_can_t cp;
   logic [15:0] tmr;
   int n_fail = 0;
   int n_compared = 0;
   int exp_mode = 0;
   int cnt;

   hipc_top dut (.clk(clk), .rst(rst), .halt_option_en(opt), .halt_req_wr(hwr), .halt_req_wdata(wd),
      .idle_req_wr(iwr), .idle_req_wdata(wd), .can_rx_comp_enable_0(en0), .can_rx_comp_enable_1(en1),
      .portm_wake_enable_reg(mwen), .portm_wake_pending(mp), .portl_wake_enable(lwen),
      .portl_wake_pending(lp), .reset_pin_n(rpin_n), .idle_timer_int_enable(ien),
      .idle_timer_pending_clr(pclr), .halt_request_bit(hbit), .idle_request_bit(ibit), .status(st),
      .can_power(cp), .can_vref_oe_n(oe_n), .idle_timer(tmr), .idle_timer_pending(pend),
      .idle_timer_irq(irq), .resume_isr(risr), .resume_next(rnext));

   hipc_wake_model partner (.clk(clk), .ev(ev), .clr(clr), .press(press), .portl_pend(lp),
      .portm_pend(mp), .reset_pin_n(rpin_n));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // The model keeps only the expected mode; every flag checked here follows from it.
   task automatic state_ok;
      chk("mode", 16'(exp_mode), 16'(st.mode));
      chk("sys clk", 16'(exp_mode == 0), 16'(st.sys_clk_enable));
      chk("osc", 16'(exp_mode != 1), 16'(st.osc_enable));
      chk("halt bit", 16'(exp_mode % 2), 16'(hbit));
      chk("idle bit", 16'(exp_mode == 2), 16'(ibit));
   endtask

   task automatic req(input logic h);
      @(posedge clk);
      hwr <= h;
      iwr <= !h;
      @(posedge clk);
      hwr <= 1'b0;
      iwr <= 1'b0;
      @(negedge clk);
   endtask

   task automatic pulse(input logic [15:0] v, input logic c);
      @(posedge clk);
      ev <= v;
      clr <= c;
      @(posedge clk);
      ev <= 16'h0000;
      clr <= 1'b0;
   endtask

   task automatic wait_mode(input int m, input int lim);
      cnt = 0;
      while (int'(st.mode) != m && cnt < lim) begin
         cyc(1);
         cnt++;
      end
   endtask

   task automatic gap;
      logic [15:0] t;
      t = tmr;
      cnt = 0;
      while (tmr === t && cnt < 30) begin
         cyc(1);
         cnt++;
      end
   endtask

   task automatic end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #(110000 * 100);
      n_fail++;
      end_sim;
   end

   initial begin
      void'($urandom(32'h4ce4));
      cyc(9);
      state_ok;
      chk("timer", 16'h0000, tmr);
      chk("flags", 16'h0000, 16'({pend, irq, risr, rnext}));
      @(posedge clk);
      rst <= 1'b0;
      clr <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         en0 <= i[0];
         en1 <= i[1];
         mwen <= {i[2], 7'($urandom)};
         @(negedge clk);
         chk("main comp", 16'(i[1:0] != 0), 16'(cp.main_comp_on));
         chk("wake comp", 16'(i[2]), 16'(cp.wake_comp_on));
         chk("vref", 16'(i[2:0] != 0), 16'(cp.vref_on));
         chk("vref oe_n", 16'(i[2:0] == 0), 16'(oe_n));
      end
      @(posedge clk);
      en0 <= 1'b0;
      en1 <= 1'b0;
      mwen <= 8'h80;
      lwen <= 8'($urandom) | 8'h01;
      opt <= 1'b0;
      req(1'b1);
      state_ok;
      opt <= 1'b1;
      pulse(16'h0001, 1'b0);
      req(1'b1);
      state_ok;
      pulse(16'h0000, 1'b1);
      req(1'b1);
      exp_mode = 1;
      state_ok;
      chk("timer run", 16'h0000, 16'(st.timer_run));
      cnt = int'(tmr);
      cyc(40);
      chk("timer held", 16'(cnt), tmr);
      pulse(16'h0001, 1'b0);
      wait_mode(3, 5);
      exp_mode = 3;
      state_ok;
      chk("start load", 16'h0100, tmr);
      gap;
      gap;
      chk("tick gap", 16'd10, 16'(cnt));
      pulse(16'h0000, 1'b1);
      wait_mode(0, 2700);
      chk("start len", 16'h0001, 16'(cnt >= 2530 && cnt <= 2560));
      exp_mode = 0;
      state_ok;
      // The wrap after reset already set the flag, so clear it to see the wrap after start-up set it again in IDLE.
      @(posedge clk);
      pclr <= 1'b1;
      @(posedge clk);
      pclr <= 1'b0;
      cyc(1);
      chk("pend clr", 16'h0000, 16'(pend));
      req(1'b0);
      exp_mode = 2;
      state_ok;
      chk("timer run", 16'h0001, 16'(st.timer_run));
      wait_mode(0, 42000);
      exp_mode = 0;
      state_ok;
      chk("pending", 16'h0001, 16'(pend));
      chk("isr", 16'h0002, 16'({risr, rnext}));
      cyc(1);
      chk("irq", 16'h0002, 16'({irq, risr}));
      @(posedge clk);
      pclr <= 1'b1;
      ien <= 1'b0;
      @(posedge clk);
      pclr <= 1'b0;
      mwen <= 8'h7f;
      pulse(16'h8000, 1'b0);
      cyc(2);
      chk("cleared", 16'h0000, 16'({pend, irq}));
      req(1'b0);
      exp_mode = 2;
      cyc(20);
      state_ok;
      @(posedge clk);
      mwen <= 8'h80;
      wait_mode(0, 5);
      exp_mode = 0;
      state_ok;
      pulse(16'h0000, 1'b1);
      req(1'b1);
      exp_mode = 1;
      state_ok;
      press <= 1'b1;
      wait_mode(3, 10);
      exp_mode = 3;
      state_ok;
      press <= 1'b0;
      wait_mode(0, 2700);
      exp_mode = 0;
      state_ok;
      req(1'b0);
      wait_mode(0, 42000);
      state_ok;
      chk("next", 16'h0001, 16'({risr, rnext}));
      cyc(2);
      chk("masked", 16'h0002, 16'({pend, irq}));
      @(posedge clk);
      ien <= 1'b1;
      cyc(2);
      chk("unmasked", 16'h0001, 16'(irq));
      end_sim;
   end
endmodule
